// file: src/ptpcc_pin_clear.sv
// Module: synchronises the clearing pins and emits a one-cycle clear once the selected pin has held its active level for HOLD cycles
`default_nettype none
module ptpcc_pin_clear #(
	parameter int N    = ptpcc_pkg::NUM_PINS,
	parameter int HOLD = ptpcc_pkg::PIN_MIN_ACT_CYC
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [N-1:0] pins,
	input  wire logic [N-1:0] polarity,
	input  wire logic [N-1:0] dir_input,
	input  wire logic         clr_en,
	input  wire logic [2:0]   clr_sel,
	output logic              clr_pulse
);
	logic [N-1:0] s1_ff;
	logic [N-1:0] s2_ff;
	logic [N-1:0] s3_ff;
	logic [N-1:0] stable_ff;
	logic [3:0]   cnt_ff;
	logic         fired_ff;
	logic         active;

	// ==========================================================
	// Three-stage synchroniser; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff     <= '0;
			s2_ff     <= '0;
			s3_ff     <= '0;
			stable_ff <= '0;
		end else if (ce) begin
			s1_ff     <= pins;
			s2_ff     <= s1_ff;
			s3_ff     <= s2_ff;
			stable_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (stable_ff & (s2_ff ^ s3_ff));
		end
	end

	// Sense follows the pin's polarity bit; only pins set as inputs may clear
	assign active = clr_en && dir_input[clr_sel] && (stable_ff[clr_sel] == polarity[clr_sel]);

	// ==========================================================
	// Minimum active time, then one pulse per active period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff    <= '0;
			fired_ff  <= 1'b0;
			clr_pulse <= 1'b0;
		end else if (ce) begin
			clr_pulse <= 1'b0;
			if (!active) begin
				cnt_ff   <= '0;
				fired_ff <= 1'b0;
			end else if (!fired_ff) begin
				if (cnt_ff == 4'(HOLD - 1)) begin
					fired_ff  <= 1'b1;
					clr_pulse <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
		end
	end
endmodule : ptpcc_pin_clear
`default_nettype wire

// file: src/ptpcc_pkg.sv
// Package: register map, field positions, reset values and timing for the timestamp unit control block
`default_nettype none
package ptpcc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFF_CMD_CTL  = 12'h100;
	localparam logic [11:0] OFF_GEN_CFG  = 12'h104;
	localparam logic [11:0] OFF_INT_STS  = 12'h108;
	localparam logic [11:0] OFF_INT_MASK = 12'h10c;

	// ==========================================================
	// Command and control fields
	localparam int CMD_ENABLE_BIT  = 2;
	localparam int CMD_DISABLE_BIT = 1;
	localparam int CMD_RESET_BIT   = 0;

	// ==========================================================
	// General configuration fields
	localparam int CFG_PORT_EN_LSB = 16;
	localparam int CFG_PORT_EN_W   = 3;
	localparam int CFG_CLR_EN_BIT  = 15;
	localparam int CFG_CLR_SEL_LSB = 12;
	localparam int CFG_CLR_SEL_W   = 3;
	localparam logic [2:0] CFG_PORT_EN_RST = 3'h7;
	localparam logic       CFG_CLR_EN_RST  = 1'b0;
	localparam logic [2:0] CFG_CLR_SEL_RST = 3'h0;

	// ==========================================================
	// Interrupt status and mask fields
	localparam int STS_TIMER_B_BIT  = 0;
	localparam int STS_DIS_DONE_BIT = 1;
	localparam int STS_W            = 2;
	localparam logic [1:0] STS_RST  = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PIN_MIN_ACT_NS = 40;
	localparam int PIN_MIN_ACT_CYC = (PIN_MIN_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_PINS = 8;
endpackage : ptpcc_pkg
`default_nettype wire

// file: src/ptpcc_top.sv
// Module: timestamp unit control and general configuration registers behind an AXI4-Lite slave
`default_nettype none
module ptpcc_top #(
	parameter int ADDR_W = 12,
	parameter int PORTS  = 3
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Unit side
	input  wire logic              enable_strap,
	input  wire logic [PORTS-1:0]  port_frame_busy,
	input  wire logic              timer_b_event,
	input  wire logic [7:0]        gpio_pins,
	input  wire logic [7:0]        pin_polarity_bits,
	input  wire logic [7:0]        gpio_dir_input,
	output logic                   unit_enable,
	output logic [PORTS-1:0]       port_stamp_enable,
	output logic                   frame_start_allow,
	output logic                   unit_soft_reset,
	output logic                   irq
);
	// ==========================================================
	// State
	logic              aw_hold_ff;
	logic              w_hold_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;
	logic              enable_ff;
	logic              strap_done_ff;
	logic              dis_pend_ff;
	logic [2:0]        port_en_ff;
	logic              clr_en_ff;
	logic [2:0]        clr_sel_ff;
	logic [1:0]        sts_ff;
	logic [1:0]        mask_ff;
	logic [1:0]        nxt_sts;
	logic              wr_go;
	logic              rd_go;
	logic              cmd_reset;
	logic              drain_done;
	logic              pin_clr;
	logic              cmd_wr;
	logic              cfg_wr;
	logic              mask_wr;
	logic              sts_rd;
	logic              unit_live;
	logic              strap_s1_ff;
	logic              strap_s2_ff;
	logic              strap_s3_ff;

	// Register decode shared by reads and writes
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_W'(ptpcc_pkg::OFF_CMD_CTL)) || (a == ADDR_W'(ptpcc_pkg::OFF_GEN_CFG)) ||
			(a == ADDR_W'(ptpcc_pkg::OFF_INT_STS)) || (a == ADDR_W'(ptpcc_pkg::OFF_INT_MASK));
	endfunction : is_mapped

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		hit = (a == ADDR_W'(off));
	endfunction : hit

	assign wr_go     = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign rd_go     = s_axi_arvalid && s_axi_arready;
	// Register strobes; command bits and mask sit in byte lane zero
	assign cmd_wr    = wr_go && hit(awaddr_ff, ptpcc_pkg::OFF_CMD_CTL) && wstrb_ff[0];
	assign cfg_wr    = wr_go && hit(awaddr_ff, ptpcc_pkg::OFF_GEN_CFG);
	assign mask_wr   = wr_go && hit(awaddr_ff, ptpcc_pkg::OFF_INT_MASK) && wstrb_ff[0];
	assign sts_rd    = rd_go && hit(s_axi_araddr, ptpcc_pkg::OFF_INT_STS);
	assign cmd_reset = cmd_wr && wdata_ff[ptpcc_pkg::CMD_RESET_BIT];
	assign drain_done = dis_pend_ff && (port_frame_busy == '0);
	// A reset command drops the unit outputs on its own edge, so frame edits halt at once
	assign unit_live = enable_ff && !cmd_reset;

	// ==========================================================
	// Write address and data, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff    <= 1'b0;
			w_hold_ff     <= 1'b0;
			awaddr_ff     <= '0;
			wdata_ff      <= '0;
			wstrb_ff      <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ptpcc_pkg::RESP_OKAY;
		end else if (ce) begin
			if (!aw_hold_ff && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (!w_hold_ff && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff    <= 1'b1;
				awaddr_ff     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff    <= 1'b1;
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_ff   <= 1'b0;
				w_hold_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(awaddr_ff) ? ptpcc_pkg::RESP_OKAY : ptpcc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ptpcc_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= is_mapped(s_axi_araddr) ? ptpcc_pkg::RESP_OKAY : ptpcc_pkg::RESP_SLVERR;
				s_axi_rdata   <= '0;
				if (hit(s_axi_araddr, ptpcc_pkg::OFF_CMD_CTL)) begin
					s_axi_rdata[ptpcc_pkg::CMD_ENABLE_BIT] <= enable_ff;
				end else if (hit(s_axi_araddr, ptpcc_pkg::OFF_GEN_CFG)) begin
					s_axi_rdata[ptpcc_pkg::CFG_PORT_EN_LSB +: ptpcc_pkg::CFG_PORT_EN_W] <= port_en_ff;
					s_axi_rdata[ptpcc_pkg::CFG_CLR_EN_BIT] <= clr_en_ff;
					s_axi_rdata[ptpcc_pkg::CFG_CLR_SEL_LSB +: ptpcc_pkg::CFG_CLR_SEL_W] <= clr_sel_ff;
				end else if (hit(s_axi_araddr, ptpcc_pkg::OFF_INT_STS)) begin
					s_axi_rdata[ptpcc_pkg::STS_W-1:0] <= sts_ff;
				end else if (hit(s_axi_araddr, ptpcc_pkg::OFF_INT_MASK)) begin
					s_axi_rdata[ptpcc_pkg::STS_W-1:0] <= mask_ff;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end else if (!s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Strap synchroniser; kept out of reset so it holds the strap level at release
	always_ff @(posedge aclk) begin
		if (ce) begin
			strap_s1_ff <= enable_strap;
			strap_s2_ff <= strap_s1_ff;
			strap_s3_ff <= strap_s2_ff;
		end
	end

	// ==========================================================
	// Global enable, graceful disable and strap load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_ff     <= 1'b0;
			strap_done_ff <= 1'b0;
			dis_pend_ff   <= 1'b0;
		end else if (ce) begin
			if (!strap_done_ff) begin
				if (strap_s2_ff == strap_s3_ff) begin
					strap_done_ff <= 1'b1;
					enable_ff     <= strap_s3_ff;
				end
			end else if (cmd_reset) begin
				enable_ff   <= 1'b0;
				dis_pend_ff <= 1'b0;
			end else begin
				if (drain_done) begin
					enable_ff   <= 1'b0;
					dis_pend_ff <= 1'b0;
				end
				if (cmd_wr) begin
					if (wdata_ff[ptpcc_pkg::CMD_ENABLE_BIT]) begin
						enable_ff <= 1'b1;
					end
					if (wdata_ff[ptpcc_pkg::CMD_DISABLE_BIT] && (enable_ff || dis_pend_ff)) begin
						dis_pend_ff <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// General configuration
	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && cmd_reset)) begin
			port_en_ff <= ptpcc_pkg::CFG_PORT_EN_RST;
			clr_en_ff  <= ptpcc_pkg::CFG_CLR_EN_RST;
			clr_sel_ff <= ptpcc_pkg::CFG_CLR_SEL_RST;
		end else if (ce && cfg_wr) begin
			if (wstrb_ff[2]) begin
				port_en_ff <= wdata_ff[ptpcc_pkg::CFG_PORT_EN_LSB +: ptpcc_pkg::CFG_PORT_EN_W];
			end
			if (wstrb_ff[1]) begin
				clr_en_ff  <= wdata_ff[ptpcc_pkg::CFG_CLR_EN_BIT];
				clr_sel_ff <= wdata_ff[ptpcc_pkg::CFG_CLR_SEL_LSB +: ptpcc_pkg::CFG_CLR_SEL_W];
			end
		end
	end

	// ==========================================================
	// Pin-driven clear of the timer B flag
	// The clear lasts one cycle, so a pin held active cannot keep the flag down
	ptpcc_pin_clear #(
		.N    (ptpcc_pkg::NUM_PINS),
		.HOLD (ptpcc_pkg::PIN_MIN_ACT_CYC)
	) u_pin_clear (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.pins      (gpio_pins),
		.polarity  (pin_polarity_bits),
		.dir_input (gpio_dir_input),
		.clr_en    (clr_en_ff),
		.clr_sel   (clr_sel_ff),
		.clr_pulse (pin_clr)
	);

	// ==========================================================
	// Interrupt status: read clears, pin clears timer B, a new event wins
	always_comb begin
		nxt_sts = sts_ff;
		if (sts_rd) begin
			nxt_sts = '0;
		end
		if (pin_clr) begin
			nxt_sts[ptpcc_pkg::STS_TIMER_B_BIT] = 1'b0;
		end
		if (timer_b_event) begin
			nxt_sts[ptpcc_pkg::STS_TIMER_B_BIT] = 1'b1;
		end
		if (drain_done && !cmd_reset && strap_done_ff) begin
			nxt_sts[ptpcc_pkg::STS_DIS_DONE_BIT] = 1'b1;
		end
		if (cmd_reset) begin
			nxt_sts = ptpcc_pkg::STS_RST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_ff <= ptpcc_pkg::STS_RST;
		end else if (ce) begin
			sts_ff <= nxt_sts;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && cmd_reset)) begin
			mask_ff <= ptpcc_pkg::MASK_RST;
		end else if (ce && mask_wr) begin
			mask_ff <= wdata_ff[ptpcc_pkg::STS_W-1:0];
		end
	end

	// ==========================================================
	// Registered unit outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_enable       <= 1'b0;
			port_stamp_enable <= '0;
			frame_start_allow <= 1'b0;
			unit_soft_reset   <= 1'b0;
			irq               <= 1'b0;
		end else if (ce) begin
			unit_enable       <= unit_live;
			port_stamp_enable <= unit_live ? PORTS'(port_en_ff) : '0;
			frame_start_allow <= unit_live && !dis_pend_ff;
			unit_soft_reset   <= cmd_reset;
			// Level taken from the next status so it moves on the same edge as the flag
			irq               <= |(nxt_sts & mask_ff);
		end
	end
endmodule : ptpcc_top
`default_nettype wire

// file: verif/ptp_unit_control_config_test.sv
// Self-checking bench for the timestamp control block
`default_nettype none
module ptp_unit_control_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic enable_strap = 1'b1;
	logic [2:0] port_frame_busy = 3'h0;
	logic timer_b_event = 1'b0;
	logic [7:0] gpio_pins = 8'hff;
	logic [7:0] pin_polarity_bits = 8'hd7;
	logic [7:0] gpio_dir_input = 8'hff;
	logic unit_enable;
	logic [2:0] port_stamp_enable;
	logic frame_start_allow;
	logic unit_soft_reset;
	logic irq;
	logic [31:0] rv;
	logic [1:0] rr;
	int err_count = 0;
	int checks_done = 0;
	int sr_seen = 0;

	ptpcc_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.enable_strap, .port_frame_busy, .timer_b_event, .gpio_pins, .pin_polarity_bits, .gpio_dir_input,
		.unit_enable, .port_stamp_enable, .frame_start_allow, .unit_soft_reset, .irq);

	always #5 aclk = ~aclk;

	always @(posedge aclk)
		if (unit_soft_reset === 1'b1)
			sr_seen++;

	// ==========
	// Bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic wrc(input logic [11:0] a, input logic [31:0] d);
		wr(a, d, rr);
		chk(32'(rr), 32'(ptpcc_pkg::RESP_OKAY));
	endtask : wrc

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		rd(a, rv, rr);
		chk(rv, e);
		chk(32'(rr), 32'(ptpcc_pkg::RESP_OKAY));
	endtask : rdc

	task automatic evt;
		@(posedge aclk);
		timer_b_event <= 1'b1;
		@(posedge aclk);
		timer_b_event <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : evt

	// Pulses one pin low for n cycles, then lets the clear path settle
	task automatic pin(input int i, input int n);
		gpio_pins[i] <= 1'b0;
		repeat (n) @(posedge aclk);
		gpio_pins[i] <= 1'b1;
		repeat (14) @(posedge aclk);
	endtask : pin

	task automatic test_done;
		$display("Mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	initial begin
		#50us;
		err_count++;
		test_done();
	end

	// ==========
	// Tests
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(32'(unit_enable), 32'h1);
		chk(32'(frame_start_allow), 32'h1);
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h4);
		rdc(ptpcc_pkg::OFF_GEN_CFG, 32'h70000);
		chk(32'(port_stamp_enable), 32'h7);
		port_frame_busy <= 3'h2;
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h2);
		repeat (4) @(posedge aclk);
		chk(32'(frame_start_allow), 32'h0);
		chk(32'(unit_enable), 32'h1);
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h4);
		port_frame_busy <= 3'h0;
		repeat (4) @(posedge aclk);
		chk(32'(unit_enable), 32'h0);
		rdc(ptpcc_pkg::OFF_INT_STS, 32'h2);
		rdc(ptpcc_pkg::OFF_INT_STS, 32'h0);
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h0);
		repeat (2) @(posedge aclk);
		chk(32'(unit_enable), 32'h0);
		wrc(ptpcc_pkg::OFF_GEN_CFG, 32'hffffffff);
		rdc(ptpcc_pkg::OFF_GEN_CFG, 32'h7f000);
		wrc(ptpcc_pkg::OFF_GEN_CFG, 32'h30000);
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h4);
		repeat (2) @(posedge aclk);
		chk(32'(port_stamp_enable), 32'h3);
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h4);
		// Reset command while frames are still in flight
		port_frame_busy <= 3'h7;
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h1);
		repeat (2) @(posedge aclk);
		chk(32'(unit_enable), 32'h0);
		chk(32'(sr_seen), 32'h1);
		rdc(ptpcc_pkg::OFF_GEN_CFG, 32'h70000);
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h0);
		port_frame_busy <= 3'h0;
		wrc(ptpcc_pkg::OFF_INT_MASK, 32'h1);
		rdc(ptpcc_pkg::OFF_INT_MASK, 32'h1);
		evt();
		chk(32'(irq), 32'h1);
		rdc(ptpcc_pkg::OFF_INT_STS, 32'h1);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		wrc(ptpcc_pkg::OFF_INT_MASK, 32'h0);
		evt();
		chk(32'(irq), 32'h0);
		rdc(ptpcc_pkg::OFF_INT_STS, 32'h1);
		// Pin clear of the timer flag, pin five active low
		wrc(ptpcc_pkg::OFF_INT_MASK, 32'h1);
		wrc(ptpcc_pkg::OFF_GEN_CFG, 32'h7d000);
		evt();
		pin(5, 2);
		chk(32'(irq), 32'h1);
		pin(3, 10);
		chk(32'(irq), 32'h1);
		pin(5, 10);
		chk(32'(irq), 32'h0);
		// Reset command once software has read the unit as off
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h0);
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h1);
		rdc(ptpcc_pkg::OFF_GEN_CFG, 32'h70000);
		rdc(ptpcc_pkg::OFF_INT_MASK, 32'h0);
		// Clock enable low: a timer event must be ignored
		ce <= 1'b0;
		evt();
		ce <= 1'b1;
		rdc(ptpcc_pkg::OFF_INT_STS, 32'h0);
		// Mid-run reset with the strap low leaves the unit off
		wrc(ptpcc_pkg::OFF_CMD_CTL, 32'h4);
		enable_strap <= 1'b0;
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(32'(unit_enable), 32'h0);
		rdc(ptpcc_pkg::OFF_CMD_CTL, 32'h0);
		rd(12'h200, rv, rr);
		chk(32'(rr), 32'(ptpcc_pkg::RESP_SLVERR));
		chk(rv, 32'h0);
		wr(12'h200, 32'h1, rr);
		chk(32'(rr), 32'(ptpcc_pkg::RESP_SLVERR));
		test_done();
	end
endmodule : ptp_unit_control_config_test
`default_nettype wire

// file: verif/ptpcc_checker.sv
// Concurrent checks on the timestamp control block ports
`default_nettype none
module ptpcc_checker #(
	parameter int PORTS = 3
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             ce,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [PORTS-1:0] port_frame_busy,
	input wire logic             unit_enable,
	input wire logic [PORTS-1:0] port_stamp_enable,
	input wire logic             frame_start_allow,
	input wire logic             unit_soft_reset,
	input wire logic             irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========
	// Bus answers
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
		|=> ##1 s_axi_bvalid) else $error("write response missing");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
		else $error("read response missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	// ==========
	// Unit control
	port_gate_a: assert property (|port_stamp_enable |-> unit_enable)
		else $error("port stamping without global enable");
	start_gate_a: assert property (frame_start_allow |-> unit_enable)
		else $error("frame start allowed while off");
	drain_off_a: assert property ($fell(unit_enable) |-> unit_soft_reset || $past(port_frame_busy, 2) == '0)
		else $error("enable cleared with frames busy");
	reset_off_a: assert property (unit_soft_reset |-> !unit_enable && !frame_start_allow && port_stamp_enable == '0)
		else $error("unit active during reset command");
	reset_pulse_a: assert property (unit_soft_reset |=> !unit_soft_reset)
		else $error("reset command pulse too long");
	freeze_a: assert property (!ce |=> $stable(unit_enable) && $stable(port_stamp_enable) && $stable(irq) &&
		$stable(frame_start_allow) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
		else $error("state moved while clock enable low");
	cover property (unit_soft_reset);
	cover property ($fell(unit_enable) && !unit_soft_reset);
	cover property ($fell(irq));
endmodule : ptpcc_checker
bind ptpcc_top ptpcc_checker #(.PORTS(PORTS)) chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_frame_busy, .unit_enable, .port_stamp_enable,
	.frame_start_allow, .unit_soft_reset, .irq);
`default_nettype wire
